// *** core/rtcwa_pkg.sv ***
package rtcwa_pkg;

  // Byte addresses of the registers on the Wishbone slave.
  localparam int         ADDR_W         = 5;
  localparam logic [ADDR_W-1:0] A_CFG   = 5'h00;
  localparam logic [ADDR_W-1:0] A_PWC   = 5'h04;
  localparam logic [ADDR_W-1:0] A_KEY   = 5'h08;
  localparam logic [ADDR_W-1:0] A_TWIN  = 5'h0c;
  localparam logic [ADDR_W-1:0] A_AWIN  = 5'h10;

  // Field positions.
  localparam int CFG_WREN_BIT = 13;
  localparam int CFG_PTR_LO   = 8;
  localparam int PWC_SRC_LO   = 10;
  localparam int PWC_STAB_LO  = 8;

  // Unlock key values, in order.
  localparam logic [7:0] KEY_FIRST  = 8'h55;
  localparam logic [7:0] KEY_SECOND = 8'haa;

  // Pointer values.
  localparam logic [1:0] PTR_ZERO = 2'h0;
  localparam logic [1:0] PTR_MAX  = 2'h3;

  // Reference source encodings.
  typedef enum logic [1:0] {
    SRC_SEC_OSC = 2'h0,
    SRC_LOW_POWER_RC_OSCILLATOR    = 2'h1,
    SRC_EXT_50  = 2'h2,
    SRC_EXT_60  = 2'h3
  } rtcwa_src_t;

  // Unlock sequence states.
  typedef enum logic [1:0] {
    KEY_IDLE,
    KEY_GOT_FIRST,
    KEY_OPEN
  } rtcwa_key_t;

  // Wishbone request as seen by the slave.
  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [3:0]  sel;
    logic [ADDR_W-1:0] adr;
    logic [31:0] dat;
  } rtcwa_wb_req_t;

endpackage

// *** core/rtcwa_window.sv ***
`timescale 1ns/1ps
// Notes on behaviour
// - Alarm window read decrements alarm pointer.
// - Timer window read decrements timer pointer.
// - Window writes never trigger read decrement.
// - Timer writes accepted only with write enable.
// - Enable settable only right after 55h/AAh.
// - Bits 11:10 select reference clock source.
// - Config bits 9:8 select timer pair.
// - Alarm high-byte write decrements, stops at 00.
module rtcwa_window (
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [4:0]  wb_adr_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  output logic      [1:0]  reference_source_select,
  output logic             timer_write_enable
);

  // Register map seen by software: configuration, power control, unlock key,
  // timer window and alarm window. The two windows are 16 bits wide and sit in
  // byte lanes one and zero; lane one is the high byte, lane zero the low byte.
  // Every access is answered one cycle after it is taken, whatever the address,
  // so software never waits longer on an unmapped address than on a real one.

  // Everything the block remembers sits in one packed struct, registered in one place.
  // The alarm side keeps three pairs only; pointer value three shows power-control bytes.
  typedef struct packed {
    logic                  ack;
    logic [31:0]           rdat;
    logic                  wren;
    logic [1:0]            tptr;
    logic [1:0]            aptr;
    rtcwa_pkg::rtcwa_src_t src;
    logic [7:0]            stab;
    logic [7:0]            samp;
    rtcwa_pkg::rtcwa_key_t key;
    logic [3:0][15:0]      tmr;
    logic [2:0][15:0]      alm;
  } rtcwa_state_t;

  rtcwa_state_t st_ff;
  rtcwa_state_t nxt_st;

  // Pointer decrement that saturates at zero.
  // Both windows use it, on reads and on high-byte writes alike.
  function automatic logic [1:0] rtcwa_dec(input logic [1:0] p);
    if (p == rtcwa_pkg::PTR_ZERO) begin
      rtcwa_dec = rtcwa_pkg::PTR_ZERO;
    end else begin
      rtcwa_dec = p - 2'h1;
    end
  endfunction

  // Merge a write into a 16-bit pair under the two low byte enables.
  // Lanes two and three carry nothing for a window and are ignored.
  function automatic logic [15:0] rtcwa_merge(input logic [15:0] old, input logic [31:0] d, input logic [3:0] s);
    logic [7:0] hi;
    logic [7:0] lo;
    hi = s[1] ? d[15:8] : old[15:8];
    lo = s[0] ? d[7:0] : old[7:0];
    rtcwa_merge = {hi, lo};
  endfunction

  // Read view of the configuration register; unmapped bits read as zero.
  function automatic logic [31:0] rtcwa_cfg_view(input rtcwa_state_t s);
    logic [31:0] v;
    v = 32'h0;
    v[rtcwa_pkg::CFG_WREN_BIT] = s.wren;
    v[rtcwa_pkg::CFG_PTR_LO +: 2] = s.tptr;
    rtcwa_cfg_view = v;
  endfunction

  // Read view of the power-control register; unmapped bits read as zero.
  // The alarm pointer lives here, next to the source select.
  function automatic logic [31:0] rtcwa_pwc_view(input rtcwa_state_t s);
    logic [31:0] v;
    v = 32'h0;
    v[rtcwa_pkg::PWC_SRC_LO +: 2] = s.src;
    v[rtcwa_pkg::PWC_STAB_LO +: 2] = s.aptr;
    v[7:0] = s.samp;
    v[31:24] = s.stab;
    rtcwa_pwc_view = v;
  endfunction

  // Timer window view. The fourth pair holds the year in its low byte only,
  // so its high byte reads as zero whatever was written there.
  function automatic logic [15:0] rtcwa_tmr_view(input rtcwa_state_t s);
    logic [15:0] v;
    v = s.tmr[s.tptr];
    if (s.tptr == rtcwa_pkg::PTR_MAX) begin
      v[15:8] = 8'h00;
    end
    rtcwa_tmr_view = v;
  endfunction

  // Alarm window view. A pointer of three shows the power-control values instead
  // of a pair; the case keeps every pair index inside the three stored pairs.
  function automatic logic [15:0] rtcwa_alm_view(input rtcwa_state_t s);
    logic [15:0] v;
    unique case (s.aptr)
      2'h0: begin
        v = s.alm[0];
      end
      2'h1: begin
        v = s.alm[1];
      end
      2'h2: begin
        v = s.alm[2];
      end
      2'h3: begin
        v = {s.stab, s.samp};
      end
    endcase
    rtcwa_alm_view = v;
  endfunction

  // Alarm pair store. Pointer three is only a view of the power-control bytes,
  // so a write there stores nothing; the bytes are changed through their own register.
  function automatic logic [2:0][15:0] rtcwa_alm_store(input rtcwa_state_t s, input logic [31:0] d,
                                                       input logic [3:0] sel);
    logic [2:0][15:0] a;
    a = s.alm;
    unique case (s.aptr)
      2'h0: begin
        a[0] = rtcwa_merge(s.alm[0], d, sel);
      end
      2'h1: begin
        a[1] = rtcwa_merge(s.alm[1], d, sel);
      end
      2'h2: begin
        a[2] = rtcwa_merge(s.alm[2], d, sel);
      end
      2'h3: begin
        a = s.alm;
      end
    endcase
    rtcwa_alm_store = a;
  endfunction

  // Unlock sequence. Only the first key followed directly by the second key opens
  // the window, and the window lasts for exactly one access after that. Any other
  // access in between starts over, which guards against a stray write setting the
  // enable; the price is that software must keep the three accesses back to back.
  function automatic rtcwa_pkg::rtcwa_key_t rtcwa_key_next(input rtcwa_pkg::rtcwa_key_t k,
                                                          input logic key_wr, input logic [7:0] d);
    rtcwa_pkg::rtcwa_key_t n;
    n = rtcwa_pkg::KEY_IDLE;
    if (key_wr) begin
      if (d == rtcwa_pkg::KEY_FIRST) begin
        n = rtcwa_pkg::KEY_GOT_FIRST;
      end else if (k == rtcwa_pkg::KEY_GOT_FIRST && d == rtcwa_pkg::KEY_SECOND) begin
        n = rtcwa_pkg::KEY_OPEN;
      end
    end
    rtcwa_key_next = n;
  endfunction

  // Bus decode. A request is taken only on an edge with no answer pending, so a
  // request the master still holds while ack is up is never counted twice.
  logic req;
  logic wr;
  logic rd;
  logic sel_hi;
  logic sel_lo;
  logic key_wr;

  assign req    = wb_cyc_i & wb_stb_i & ~st_ff.ack;
  assign wr     = req & wb_we_i;
  assign rd     = req & ~wb_we_i;
  assign sel_hi = wb_sel_i[1];
  assign sel_lo = wb_sel_i[0];
  assign key_wr = wr & sel_lo & (wb_adr_i == rtcwa_pkg::A_KEY);

  // Next state. Every taken request is answered on the following edge with a
  // one-cycle ack; read data stands for that cycle only and is zero otherwise.
  always_comb begin
    nxt_st      = st_ff;
    nxt_st.ack  = req;
    nxt_st.rdat = 32'h0;
    // The unlock state moves on every taken access, so the window closes after one access.
    if (req) begin
      nxt_st.key = rtcwa_key_next(st_ff.key, key_wr, wb_dat_i[7:0]);
    end
    // Reads. Window reads step their pointer down whatever the byte lanes, since
    // the bus cannot tell a byte read from a word read.
    if (rd) begin
      unique case (wb_adr_i)
        rtcwa_pkg::A_CFG: begin
          nxt_st.rdat = rtcwa_cfg_view(st_ff);
        end
        rtcwa_pkg::A_PWC: begin
          nxt_st.rdat = rtcwa_pwc_view(st_ff);
        end
        rtcwa_pkg::A_TWIN: begin
          nxt_st.rdat = {16'h0, rtcwa_tmr_view(st_ff)};
          nxt_st.tptr = rtcwa_dec(st_ff.tptr);
        end
        rtcwa_pkg::A_AWIN: begin
          nxt_st.rdat = {16'h0, rtcwa_alm_view(st_ff)};
          nxt_st.aptr = rtcwa_dec(st_ff.aptr);
        end
        default: begin
          nxt_st.rdat = 32'h0;
        end
      endcase
    end
    // Writes. Unmapped addresses and absent byte lanes change nothing.
    if (wr) begin
      unique case (wb_adr_i)
        rtcwa_pkg::A_KEY: begin
          // The key is never stored; only the unlock state above remembers it.
          nxt_st.key = rtcwa_key_next(st_ff.key, key_wr, wb_dat_i[7:0]);
        end
        rtcwa_pkg::A_CFG: begin
          if (sel_hi) begin
            nxt_st.tptr = wb_dat_i[rtcwa_pkg::CFG_PTR_LO +: 2];
            // Clearing is always allowed; setting only inside the unlock window.
            if (!wb_dat_i[rtcwa_pkg::CFG_WREN_BIT]) begin
              nxt_st.wren = 1'b0;
            end else if (st_ff.key == rtcwa_pkg::KEY_OPEN) begin
              nxt_st.wren = 1'b1;
            end
          end
        end
        rtcwa_pkg::A_PWC: begin
          if (sel_hi) begin
            nxt_st.src  = rtcwa_pkg::rtcwa_src_t'(wb_dat_i[rtcwa_pkg::PWC_SRC_LO +: 2]);
            nxt_st.aptr = wb_dat_i[rtcwa_pkg::PWC_STAB_LO +: 2];
          end
          if (sel_lo) begin
            nxt_st.samp = wb_dat_i[7:0];
          end
          if (wb_sel_i[3]) begin
            nxt_st.stab = wb_dat_i[31:24];
          end
        end
        rtcwa_pkg::A_TWIN: begin
          // Low-byte writes leave the pointer alone; the read decrement never fires here.
          if (st_ff.wren) begin
            nxt_st.tmr[st_ff.tptr] = rtcwa_merge(st_ff.tmr[st_ff.tptr], wb_dat_i, wb_sel_i);
            if (sel_hi) begin
              nxt_st.tptr = rtcwa_dec(st_ff.tptr);
            end
          end
        end
        rtcwa_pkg::A_AWIN: begin
          // Same pointer rule as the timer window, but the alarm side has no write lock.
          nxt_st.alm = rtcwa_alm_store(st_ff, wb_dat_i, wb_sel_i);
          if (sel_hi) begin
            nxt_st.aptr = rtcwa_dec(st_ff.aptr);
          end
        end
        default: begin
          nxt_st.rdat = 32'h0;
        end
      endcase
    end
  end

  // State register; reset clears the write enable and all pointers.
  // Reset also closes the unlock sequence, so a key pair written just before a
  // reset can never open the window afterwards.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign wb_ack_o                = st_ff.ack;
  assign wb_dat_o                = st_ff.rdat;
  assign reference_source_select = st_ff.src;
  assign timer_write_enable      = st_ff.wren;

endmodule

// *** test/rtcwa_window_checker.sv ***
`timescale 1ns/1ps
// Watches the bus answer and the two level outputs of the window block.
module rtcwa_chk (
  input wire logic        clk,
  input wire logic        sys_rst,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic [4:0]  wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire logic [1:0]  reference_source_select,
  input wire logic        timer_write_enable
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  // A request is taken only when no answer is pending, so a held request is not counted twice.
  wire logic tk = wb_cyc_i && wb_stb_i && !wb_ack_o;
  a_ack_one_late: assert property (tk |=> wb_ack_o) else $error("ack not one cycle after request");
  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack longer than one cycle");
  a_src_follows: assert property (
    tk && wb_we_i && wb_sel_i[1] && wb_adr_i == rtcwa_pkg::A_PWC
    |-> ##2 reference_source_select == $past(wb_dat_i[11:10], 2)) else $error("source select not written");
  a_src_cause: assert property (
    $changed(reference_source_select) |-> $past(wb_we_i && wb_adr_i == rtcwa_pkg::A_PWC))
    else $error("source select changed alone");
  a_wren_rise: assert property (
    $rose(timer_write_enable) |-> $past(wb_we_i && wb_adr_i == rtcwa_pkg::A_CFG && wb_dat_i[13]))
    else $error("enable rose without write");
  a_wren_fall: assert property (
    $fell(timer_write_enable) |-> $past(wb_we_i && wb_adr_i == rtcwa_pkg::A_CFG && !wb_dat_i[13]))
    else $error("enable fell without write");
  a_cfg_readback: assert property (
    wb_ack_o && !wb_we_i && wb_adr_i == rtcwa_pkg::A_CFG |-> wb_dat_o[13] == timer_write_enable)
    else $error("enable readback wrong");
  a_unmapped_zero: assert property (wb_ack_o && !wb_we_i && wb_adr_i == 5'h14 |-> wb_dat_o == 32'h0)
    else $error("unmapped read not zero");
endmodule
bind rtcwa_window rtcwa_chk u_chk (.clk(clk), .sys_rst(sys_rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_sel_i(wb_sel_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .reference_source_select(reference_source_select),
  .timer_write_enable(timer_write_enable));

// *** test/rtcwa_window_tb.sv ***
`timescale 1ns/1ps
module rtcwa_window_tb;
  logic        clk, sys_rst, cyc, stb, we, ack, wren;
  logic [3:0]  sel;
  logic [4:0]  adr;
  logic [1:0]  src;
  logic [31:0] dat, rdo, rd, v;
  logic [31:0] st = 32'h13c8b;
  logic [4:0]  ops [4] = '{5'h01, 5'h11, 5'h12, 5'h12};
  int          bad_count, samples_checked, ap;
  rtcwa_window dut (.clk(clk), .sys_rst(sys_rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_sel_i(sel), .wb_adr_i(adr), .wb_dat_i(dat), .wb_dat_o(rdo), .wb_ack_o(ack),
    .reference_source_select(src), .timer_write_enable(wren));
  // The clock runs free for the whole test.
  initial begin
    clk = 1'h0;
    forever #20 clk = ~clk;
  end
  function logic [31:0] xs();
    st ^= st << 13;
    st ^= st >> 17;
    st ^= st << 5;
    return st;
  endfunction
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  // One classic cycle: the request stands until the edge where ack is seen high,
  // read data is taken at that edge, and only then is the request dropped.
  task automatic wb(input logic w, input logic [4:0] a, input logic [31:0] d, input logic [3:0] s);
    int n = 0;
    @(posedge clk);
    {cyc, stb, we, sel, adr, dat} <= {2'h3, w, s, a, d};
    do @(posedge clk); while (ack !== 1'h1 && ++n < 40);
    if (ack !== 1'h1) bad_count++;
    rd = rdo;
    {cyc, stb} <= 2'h0;
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // The run needs some hundred cycles; a hang is cut off well after that.
  initial begin
    repeat (3000) @(posedge clk);
    bad_count++;
    summarize();
  end
  initial begin
    {cyc, stb, we, sel, adr, dat} = '0;
    sys_rst = 1'h1;
    repeat (4) @(posedge clk);
    sys_rst <= 1'h0;
    for (int i = 0; i < 4; i++) begin
      v = xs();
      v[11:10] = i[1:0];
      wb(1'h1, rtcwa_pkg::A_PWC, v, 4'hf);
      chk("source", i, src);
      wb(1'h0, rtcwa_pkg::A_PWC, 0, 4'hf);
      chk("power ctrl", v & 32'hff000fff, rd & 32'hff000fff);
    end
    v[9:8] = 2'h3;
    wb(1'h1, rtcwa_pkg::A_PWC, v, 4'hf);
    wb(1'h0, rtcwa_pkg::A_AWIN, 0, 4'h3);
    chk("alarm pair 3", {v[31:24], v[7:0]}, rd);
    ap = 2;
    // Low-byte read, low-byte write, then high-byte writes down to the floor.
    foreach (ops[k]) begin
      wb(ops[k][4], rtcwa_pkg::A_AWIN, xs(), ops[k][3:0]);
      ap = ap - ((!ops[k][4] || ops[k][1]) && ap > 0);
      wb(1'h0, rtcwa_pkg::A_PWC, 0, 4'hf);
      chk("alarm pointer", ap, rd[9:8]);
    end
    wb(1'h1, rtcwa_pkg::A_CFG, 32'h2000, 4'hf);
    chk("enable no key", 0, wren);
    wb(1'h1, rtcwa_pkg::A_KEY, 32'h55, 4'h1);
    wb(1'h1, rtcwa_pkg::A_KEY, 32'haa, 4'h1);
    wb(1'h0, rtcwa_pkg::A_CFG, 0, 4'hf);
    wb(1'h1, rtcwa_pkg::A_CFG, 32'h2000, 4'hf);
    chk("enable late", 0, wren);
    wb(1'h1, rtcwa_pkg::A_KEY, 32'h55, 4'h1);
    wb(1'h1, rtcwa_pkg::A_KEY, 32'haa, 4'h1);
    wb(1'h1, rtcwa_pkg::A_CFG, 32'h2200, 4'hf);
    chk("enable keyed", 1, wren);
    v = xs();
    wb(1'h1, rtcwa_pkg::A_TWIN, v, 4'h3);
    wb(1'h0, rtcwa_pkg::A_CFG, 0, 4'hf);
    chk("timer pointer", 32'h2100, rd & 32'h2300);
    wb(1'h1, rtcwa_pkg::A_CFG, 32'h0200, 4'hf);
    chk("enable cleared", 0, wren);
    wb(1'h1, rtcwa_pkg::A_TWIN, ~v, 4'h3);
    wb(1'h0, rtcwa_pkg::A_TWIN, 0, 4'h1);
    chk("timer pair", v[15:0], rd[15:0]);
    wb(1'h0, rtcwa_pkg::A_CFG, 0, 4'hf);
    chk("timer pointer", 32'h0100, rd & 32'h2300);
    wb(1'h1, 5'h14, xs(), 4'hf);
    wb(1'h0, 5'h14, 0, 4'hf);
    chk("unmapped", 0, rd);
    summarize();
  end
endmodule
